// [hdl/sdq_top.sv]
// sdram mode setup, refresh timing and packet queue arbiter
`timescale 1ns/1ns

// Behaviour
// - wrap bit picks sequential (0) or interleaved (1) burst order
// - three-bit burst length code sets burst length, resets to 011
// - rising mode-write trigger writes mode and refresh values once
// - refresh period is interval value times 8 memory clocks
// - arbiter serves hdlc and mac requests; registers from index 0x3A
// - rx queue holds size times 32 slots of 2048 bytes
// - tx queue size counted in units of 32 packets
module sdq_top #(
    parameter int ADDR_W = 12,
    parameter int PTR_W = 13
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mac_req,
    input wire logic mac_dir,
    output logic mac_gnt,
    input wire logic hdlc_req,
    input wire logic hdlc_dir,
    output logic hdlc_gnt,
    output sdq_pkg::sdq_cmd_t sdram_cmd,
    output logic [6:0] sdram_mode_word,
    output logic [PTR_W:0] xfer_slot,
    output logic xfer_wr
);
    logic rst_q1, rst_n;
    logic [3:0] burst_q;
    logic [2:0] lat_q;
    logic trig_q, trig_prev_q, pend_q, ref_pend_q, prio_q;
    logic [7:0] refr_q, act_refr_q, rxq_q, txq_q;
    logic [2:0] act_bl_q;
    logic [sdq_pkg::REF_W-1:0] ref_cnt_q, ref_reload;
    logic aw_hold_q, w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb_q, do_wr, wr_hit, rd_hit;
    logic [7:0] wr_idx, rd_idx, rd_val;
    sdq_pkg::sdq_state_t state_q;
    logic [3:0] bcnt_q;
    logic go, mode_go, ref_go, gnt_any;
    logic [1:0] enq, deq, full, empty;
    logic [PTR_W-1:0] cap [2];
    logic [PTR_W:0] cnt_q [2];
    logic [PTR_W-1:0] wp_q [2];
    logic [PTR_W-1:0] rp_q [2];

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign do_wr = aw_hold_q && w_hold_q;
    assign wr_idx = 8'(awaddr_q >> sdq_pkg::ADDR_LSB);
    always_comb begin
        unique case (wr_idx)
            sdq_pkg::IDX_MODE_BURST, sdq_pkg::IDX_MODE_LAT,
            sdq_pkg::IDX_TRIG, sdq_pkg::IDX_REFRESH,
            sdq_pkg::IDX_RXQ, sdq_pkg::IDX_TXQ,
            sdq_pkg::IDX_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sdq_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb_q <= s_axi_wstrb[0];
            end else if (do_wr) begin
                w_hold_q <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? sdq_pkg::RESP_OKAY
                                      : sdq_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // config registers; only byte lane 0 carries data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_q <= sdq_pkg::RST_MODE_BURST[3:0];
            lat_q <= sdq_pkg::RST_MODE_LAT[2:0];
            trig_q <= sdq_pkg::RST_TRIG[sdq_pkg::TRIG_BIT];
            refr_q <= sdq_pkg::RST_REFRESH;
            rxq_q <= sdq_pkg::RST_RXQ;
            txq_q <= sdq_pkg::RST_TXQ;
        end else if (do_wr && wstrb_q) begin
            unique case (wr_idx)
                sdq_pkg::IDX_MODE_BURST: burst_q <= wdata_q[3:0];
                sdq_pkg::IDX_MODE_LAT: lat_q <= wdata_q[2:0];
                sdq_pkg::IDX_TRIG: trig_q <= wdata_q[sdq_pkg::TRIG_BIT];
                sdq_pkg::IDX_REFRESH: refr_q <= wdata_q;
                sdq_pkg::IDX_RXQ: rxq_q <= wdata_q;
                sdq_pkg::IDX_TXQ: txq_q <= wdata_q;
                default: ;
            endcase
        end
    end

    // read mux; status is read-only
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = 8'(s_axi_araddr >> sdq_pkg::ADDR_LSB);
    always_comb begin
        rd_hit = 1'b1;
        unique case (rd_idx)
            sdq_pkg::IDX_MODE_BURST: rd_val = {4'h0, burst_q};
            sdq_pkg::IDX_MODE_LAT: rd_val = {5'h00, lat_q};
            sdq_pkg::IDX_TRIG: rd_val = {7'h00, trig_q};
            sdq_pkg::IDX_REFRESH: rd_val = refr_q;
            sdq_pkg::IDX_RXQ: rd_val = rxq_q;
            sdq_pkg::IDX_TXQ: rd_val = txq_q;
            sdq_pkg::IDX_STATUS: rd_val = {2'h0, empty, full,
                state_q == sdq_pkg::ST_BURST, pend_q};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sdq_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_val};
            s_axi_rresp <= rd_hit ? sdq_pkg::RESP_OKAY
                                  : sdq_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // trigger edge arms one mode write; a new edge wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_q;
            if (trig_q && !trig_prev_q) begin
                pend_q <= 1'b1;
            end else if (mode_go) begin
                pend_q <= 1'b0;
            end
        end
    end

    // refresh timer runs off the interval latched at the last mode write
    assign ref_reload = sdq_pkg::REF_W'(act_refr_q *
        sdq_pkg::REFRESH_MULT * sdq_pkg::CYC_PER_MEM - 1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_q <= '0;
            ref_pend_q <= 1'b0;
        end else begin
            if (ref_cnt_q == '0) begin
                ref_cnt_q <= ref_reload;
            end else begin
                ref_cnt_q <= ref_cnt_q - 1'b1;
            end
            if (ref_cnt_q == '0) begin
                ref_pend_q <= 1'b1;
            end else if (ref_go) begin
                ref_pend_q <= 1'b0;
            end
        end
    end

    // mode write first, refresh next, transfers only when both are idle
    assign mode_go = pend_q && state_q == sdq_pkg::ST_IDLE;
    assign ref_go = ref_pend_q && !pend_q &&
                    state_q == sdq_pkg::ST_IDLE;
    assign go = state_q == sdq_pkg::ST_IDLE && !pend_q && !ref_pend_q;

    // per-queue fill state; queue 0 is mac to wan, 1 is wan to mac
    assign cap[0] = PTR_W'(rxq_q * sdq_pkg::SLOTS_PER_UNIT);
    assign cap[1] = PTR_W'(txq_q * sdq_pkg::SLOTS_PER_UNIT);
    assign enq = {hdlc_gnt && hdlc_dir, mac_gnt && mac_dir};
    assign deq = {mac_gnt && !mac_dir, hdlc_gnt && !hdlc_dir};
    generate
        for (genvar q = 0; q < 2; q++) begin : g_queue
            assign full[q] = cnt_q[q] >= {1'b0, cap[q]};
            assign empty[q] = cnt_q[q] == '0;
            // pointers wrap at the programmed capacity
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q[q] <= '0;
                    wp_q[q] <= '0;
                    rp_q[q] <= '0;
                end else begin
                    if (enq[q]) begin
                        cnt_q[q] <= cnt_q[q] + 1'b1;
                        wp_q[q] <= (wp_q[q] + 1'b1 >= cap[q]) ? '0
                                   : wp_q[q] + 1'b1;
                    end
                    if (deq[q]) begin
                        cnt_q[q] <= cnt_q[q] - 1'b1;
                        rp_q[q] <= (rp_q[q] + 1'b1 >= cap[q]) ? '0
                                   : rp_q[q] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // round robin between mac and hdlc; refused requests just wait
    logic elig_m, elig_h;
    assign elig_m = mac_req && (mac_dir ? !full[0] : !empty[1]);
    assign elig_h = hdlc_req && (hdlc_dir ? !full[1] : !empty[0]);
    assign mac_gnt = go && elig_m && (!elig_h || !prio_q);
    assign hdlc_gnt = go && elig_h && (!elig_m || prio_q);
    assign gnt_any = mac_gnt || hdlc_gnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_q <= 1'b0;
        end else if (gnt_any) begin
            prio_q <= mac_gnt;
        end
    end

    function automatic logic [3:0] beats(input logic [2:0] code);
        unique case (code)
            sdq_pkg::BL_CODE_1: beats = sdq_pkg::BEATS_1;
            sdq_pkg::BL_CODE_2: beats = sdq_pkg::BEATS_2;
            sdq_pkg::BL_CODE_4: beats = sdq_pkg::BEATS_4;
            default: beats = sdq_pkg::BEATS_8;
        endcase
    endfunction

    // sdram command sequencer; burst length is the one latched at the last mode write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sdq_pkg::ST_IDLE;
            bcnt_q <= 4'h0;
            sdram_cmd <= sdq_pkg::CMD_NOP;
            sdram_mode_word <= {sdq_pkg::RST_MODE_LAT[2:0],
                                sdq_pkg::RST_MODE_BURST[3:0]};
            act_refr_q <= sdq_pkg::RST_REFRESH;
            act_bl_q <= sdq_pkg::RST_MODE_BURST[2:0];
            xfer_slot <= '0;
            xfer_wr <= 1'b0;
        end else begin
            sdram_cmd <= sdq_pkg::CMD_NOP;
            unique case (state_q)
                sdq_pkg::ST_IDLE: begin
                    if (mode_go) begin
                        sdram_cmd <= sdq_pkg::CMD_MODE;
                        sdram_mode_word <= {lat_q, burst_q};
                        act_refr_q <= refr_q;
                        act_bl_q <= burst_q[sdq_pkg::BL_W-1:0];
                    end else if (ref_go) begin
                        sdram_cmd <= sdq_pkg::CMD_REFRESH;
                    end else if (gnt_any) begin
                        sdram_cmd <= sdq_pkg::CMD_BURST;
                        state_q <= sdq_pkg::ST_BURST;
                        bcnt_q <= beats(act_bl_q) - 1'b1;
                        xfer_wr <= mac_gnt ? mac_dir : hdlc_dir;
                        // tx slots sit above the rx region
                        if (enq[0]) xfer_slot <= {1'b0, wp_q[0]};
                        else if (deq[0]) xfer_slot <= {1'b0, rp_q[0]};
                        else if (enq[1])
                            xfer_slot <= {1'b0, cap[0]} + wp_q[1];
                        else xfer_slot <= {1'b0, cap[0]} + rp_q[1];
                    end
                end
                sdq_pkg::ST_BURST: begin
                    if (bcnt_q == 4'h0) begin
                        state_q <= sdq_pkg::ST_IDLE;
                    end else begin
                        sdram_cmd <= sdq_pkg::CMD_BURST;
                        bcnt_q <= bcnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_mode_idle: assert property (sdram_cmd == sdq_pkg::CMD_MODE |->
        state_q == sdq_pkg::ST_IDLE && $past(sdram_cmd) != sdq_pkg::CMD_BURST)
        else $error("mode during burst");
    a_mode_word: assert property (mode_go |=>
        sdram_cmd == sdq_pkg::CMD_MODE &&
        sdram_mode_word == {$past(lat_q), $past(burst_q)})
        else $error("mode word wrong");
    a_trig_edge: assert property ($rose(pend_q) |->
        $past(trig_q) && !$past(trig_prev_q))
        else $error("mode write without trigger edge");
    a_refresh_load: assert property (ref_cnt_q == '0 |=>
        ref_cnt_q == $past(ref_reload) && ref_pend_q)
        else $error("refresh period wrong");
    a_rx_bound: assert property (enq[0] |=>
        cnt_q[0] <= {1'b0, $past(cap[0])}) else $error("rx queue overfilled");
    a_tx_bound: assert property (enq[1] |->
        cnt_q[1] < {1'b0, cap[1]}) else $error("tx queue overfilled");
    a_one_grant: assert property (!(mac_gnt && hdlc_gnt))
        else $error("double grant");
    a_burst_beats: assert property (gnt_any &&
        act_bl_q == sdq_pkg::BL_CODE_2 |=>
        sdram_cmd == sdq_pkg::CMD_BURST ##1
        sdram_cmd == sdq_pkg::CMD_BURST ##1
        sdram_cmd != sdq_pkg::CMD_BURST)
        else $error("burst length wrong");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    c_mode: cover property (sdram_cmd == sdq_pkg::CMD_MODE);
    c_refresh: cover property (sdram_cmd == sdq_pkg::CMD_REFRESH);
    c_rr: cover property (mac_gnt ##[1:20] hdlc_gnt);
endmodule

// [shared/sdq_pkg.sv]
// constants and types for the sdram buffer and queue configuration block
package sdq_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_MODE_BURST = 8'h3A;
    localparam logic [7:0] IDX_MODE_LAT = 8'h3B;
    localparam logic [7:0] IDX_TRIG = 8'h3C;
    localparam logic [7:0] IDX_REFRESH = 8'h3D;
    localparam logic [7:0] IDX_RXQ = 8'h40;
    localparam logic [7:0] IDX_TXQ = 8'h41;
    localparam logic [7:0] IDX_STATUS = 8'h42;
    // reset values
    localparam logic [7:0] RST_MODE_BURST = 8'h03;
    localparam logic [7:0] RST_MODE_LAT = 8'h02;
    localparam logic [7:0] RST_TRIG = 8'h00;
    localparam logic [7:0] RST_REFRESH = 8'h46;
    localparam logic [7:0] RST_RXQ = 8'h3D;
    localparam logic [7:0] RST_TXQ = 8'h03;
    // field layout
    localparam int WT_BIT = 3;
    localparam int BL_W = 3;
    localparam int LAT_W = 3;
    localparam int TRIG_BIT = 0;
    localparam int ADDR_LSB = 2;
    // timing: refresh period is value x 8 memory clocks
    localparam int REFRESH_MULT = 8;
    localparam int CLK_MHZ = 100;
    localparam int MEM_CLK_MHZ = 100;
    localparam int CYC_PER_MEM = CLK_MHZ / MEM_CLK_MHZ;
    localparam int REF_W = 12;
    // queue sizing: size x 32 slots of 2048 bytes
    localparam int SLOTS_PER_UNIT = 32;
    localparam int SLOT_BYTES = 2048;
    // burst beat counts per burst length code
    localparam logic [3:0] BEATS_1 = 4'h1;
    localparam logic [3:0] BEATS_2 = 4'h2;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [3:0] BEATS_8 = 4'h8;
    localparam logic [2:0] BL_CODE_1 = 3'h0;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    // axi4-lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        CMD_NOP, CMD_MODE, CMD_REFRESH, CMD_BURST
    } sdq_cmd_t;
    typedef enum logic {ST_IDLE, ST_BURST} sdq_state_t;
endpackage

// [bench/sdq_mem_model.sv]
// behavioural sdram that watches the command bus of the queue block
`timescale 1ns/1ns
module sdq_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire sdq_pkg::sdq_cmd_t sdram_cmd,
    input wire logic [6:0] sdram_mode_word
);
    int cyc, last_ref, ref_gap, ref_cnt, mode_cnt;
    int beats, last_beats, burst_cnt;
    logic [6:0] mode_q;

    // latch mode word, time refreshes, count the beats of each burst
    // a mode command in mid-burst ends the burst early, so it shows up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc <= 0;
            last_ref <= 0;
            ref_gap <= 0;
            ref_cnt <= 0;
            mode_cnt <= 0;
            beats <= 0;
            last_beats <= 0;
            burst_cnt <= 0;
            mode_q <= 7'h00;
        end else begin
            cyc <= cyc + 1;
            if (sdram_cmd == sdq_pkg::CMD_MODE) begin
                mode_q <= sdram_mode_word;
                mode_cnt <= mode_cnt + 1;
            end
            if (sdram_cmd == sdq_pkg::CMD_REFRESH) begin
                ref_gap <= cyc - last_ref;
                last_ref <= cyc;
                ref_cnt <= ref_cnt + 1;
            end
            if (sdram_cmd == sdq_pkg::CMD_BURST) begin
                beats <= beats + 1;
            end else if (beats != 0) begin
                last_beats <= beats;
                burst_cnt <= burst_cnt + 1;
                beats <= 0;
            end
        end
    end
endmodule

// [bench/sdram_buffer_queue_config_tb.sv]
// self-checking bench for the sdram buffer and queue configuration block
`timescale 1ns/1ns
module sdram_buffer_queue_config_tb;
    logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, xfer_wr, g;
    logic mac_req, mac_dir, mac_gnt, hdlc_req, hdlc_dir, hdlc_gnt;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    logic [6:0] mode_word;
    logic [13:0] xfer_slot;
    sdq_pkg::sdq_cmd_t cmd;
    int fail_count, checks_done, cycles, k;

    sdq_top uut (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mac_req(mac_req), .mac_dir(mac_dir),
        .mac_gnt(mac_gnt), .hdlc_req(hdlc_req), .hdlc_dir(hdlc_dir),
        .hdlc_gnt(hdlc_gnt), .sdram_cmd(cmd), .sdram_mode_word(mode_word),
        .xfer_slot(xfer_slot), .xfer_wr(xfer_wr)
    );
    sdq_mem_model mem (
        .clk(clk), .rst_b(rst_b), .sdram_cmd(cmd),
        .sdram_mode_word(mode_word)
    );

    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard, well above the 1600 or so cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // axi write; bready stays high so the answer is taken when it shows
    task automatic wr(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] r);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, r});
    endtask

    // axi read and compare of data and response
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] e,
                          input logic [1:0] r);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, r});
    endtask

    // clear then set the trigger and wait for the mode command
    task automatic toggle();
        int n;
        n = mem.mode_cnt;
        wr(8'h3C, 8'h00, 2'h0);
        wr(8'h3C, 8'h01, 2'h0);
        repeat (20) if (mem.mode_cnt == n) @(posedge clk);
    endtask

    // hold a request until granted or give up; then wait out the burst
    task automatic xfer(input logic m, input logic d, output logic ok);
        int n;
        n = mem.burst_cnt;
        ok = 1'b0;
        @(posedge clk);
        mac_req <= m;
        hdlc_req <= !m;
        mac_dir <= d;
        hdlc_dir <= d;
        repeat (40) if (!ok) begin
            @(negedge clk);
            ok = ((m ? mac_gnt : hdlc_gnt) === 1'b1);
        end
        @(posedge clk);
        mac_req <= 1'b0;
        hdlc_req <= 1'b0;
        repeat (30) if (ok && mem.burst_cnt == n) @(posedge clk);
    endtask

    task automatic reset_values();
        rd_chk(8'h3A, 8'h03, 2'h0);
        rd_chk(8'h3B, 8'h02, 2'h0);
        rd_chk(8'h3C, 8'h00, 2'h0);
        rd_chk(8'h3D, 8'h46, 2'h0);
        rd_chk(8'h40, 8'h3D, 2'h0);
        rd_chk(8'h41, 8'h03, 2'h0);
        rd_chk(8'h3E, 8'h00, 2'h2);
        wr(8'h3F, 8'h55, 2'h2);
        // lane 0 strobe low: write answered but nothing stored
        wstrb <= 4'h0;
        wr(8'h3D, 8'h11, 2'h0);
        wstrb <= 4'hF;
        rd_chk(8'h3D, 8'h46, 2'h0);
        repeat (1300) if (mem.ref_cnt < 2) @(posedge clk);
        chk(mem.ref_gap, 32'h230);
    endtask

    task automatic mode_write();
        wr(8'h3A, 8'h0A, 2'h0);
        wr(8'h3B, 8'h03, 2'h0);
        wr(8'h3D, 8'h04, 2'h0);
        rd_chk(8'h3A, 8'h0A, 2'h0);
        k = mem.mode_cnt;
        toggle();
        chk({25'h0, mem.mode_q}, 32'h3A);
        chk(mem.mode_cnt, k + 1);
        wr(8'h3C, 8'h01, 2'h0);
        repeat (10) @(posedge clk);
        chk(mem.mode_cnt, k + 1);
        wr(8'h3A, 8'h02, 2'h0);
        toggle();
        chk({25'h0, mem.mode_q}, 32'h32);
    endtask

    // new interval of 4 gives a 32 cycle period once latched
    task automatic refresh_rate();
        k = mem.ref_cnt;
        repeat (1300) if (mem.ref_cnt < k + 2) @(posedge clk);
        chk(mem.ref_gap, 32'h20);
    endtask

    task automatic arbiter_paths();
        wr(8'h40, 8'h01, 2'h0);
        xfer(1'b1, 1'b1, g);
        chk({31'h0, g}, 32'h1);
        chk({31'h0, xfer_wr}, 32'h1);
        chk(mem.last_beats, 32'h4);
        xfer(1'b1, 1'b0, g);
        chk({31'h0, g}, 32'h0);
        xfer(1'b0, 1'b1, g);
        chk({31'h0, g}, 32'h1);
        chk({18'h0, xfer_slot}, 32'h20);
        xfer(1'b1, 1'b0, g);
        chk({31'h0, xfer_wr}, 32'h0);
        wr(8'h3C, 8'h00, 2'h0);
        // trigger lands while the dequeue burst runs
        fork
            xfer(1'b0, 1'b0, g);
            wr(8'h3C, 8'h01, 2'h0);
        join
        chk({31'h0, g}, 32'h1);
        chk(mem.last_beats, 32'h4);
    endtask

    // size 1 holds exactly 32 slots
    task automatic queue_full();
        k = 0;
        repeat (32) begin
            xfer(1'b1, 1'b1, g);
            k += g;
        end
        chk(k, 32'h20);
        xfer(1'b1, 1'b1, g);
        chk({31'h0, g}, 32'h0);
        xfer(1'b0, 1'b0, g);
        chk({31'h0, g}, 32'h1);
        xfer(1'b1, 1'b1, g);
        chk({31'h0, g}, 32'h1);
        // rx full, tx empty, nothing pending or running
        rd_chk(8'h42, 8'h24, 2'h0);
    endtask

    // short burst codes and the longest one, each after a mode write
    task automatic burst_lengths();
        wr(8'h3A, 8'h01, 2'h0);
        toggle();
        xfer(1'b0, 1'b1, g);
        chk(mem.last_beats, 32'h2);
        wr(8'h3A, 8'h00, 2'h0);
        toggle();
        xfer(1'b1, 1'b0, g);
        chk(mem.last_beats, 32'h1);
        wr(8'h3A, 8'h03, 2'h0);
        toggle();
        xfer(1'b0, 1'b1, g);
        chk(mem.last_beats, 32'h8);
        chk({31'h0, g}, 32'h1);
    endtask

    // reset, then the scenarios in order
    initial begin
        {rst_b, awvalid, wvalid, arvalid, mac_req, hdlc_req} = 6'h00;
        {mac_dir, hdlc_dir, awaddr, araddr, wdata} = 58'h0;
        {bready, rready} = 2'h3;
        wstrb = 4'hF;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        reset_values();
        mode_write();
        refresh_rate();
        arbiter_paths();
        queue_full();
        burst_lengths();
        complete_run();
    end
endmodule
